//--- common/ccm_pkg.sv
// Notes on behaviour
// - 112 channels on a 7 by 16 grid
// - driver on only when row, column, read
// - each driver has a monitor, merged status
// - status tells none, one or several on
// - more than one on shows as fault
// - register test: address all ones with read
// - zero indicate: address all zeros, with or without read
// - bits 1-3 column, 4-7 row, 8 form
// - word and its complement pick same channel
// - top bit tells true or complemented form
package ccm_pkg;

    // command word layout
    localparam int CMD_W = 8;
    localparam int ADDR_W = 7;
    localparam int FORM_BIT = 7;
    localparam int COL_LSB = 0;
    localparam int COL_W = 3;
    localparam int ROW_LSB = 3;
    localparam int ROW_W = 4;

    // output grid
    localparam int N_COL = 7;
    localparam int N_ROW = 16;
    localparam int N_CHAN = 112;
    localparam int CNT_W = 7;

    // column code that reaches no channel; columns use codes 1..7
    localparam logic [COL_W-1:0] COL_UNUSED = 3'h0;
    localparam logic [COL_W-1:0] COL_FIRST = 3'h1;

    // reset values and self-test patterns
    localparam logic [CMD_W-1:0] ADDR_RESET = 8'h00;
    localparam logic [CMD_W-1:0] ADDR_ALL_ONES = 8'hff;
    localparam logic [CMD_W-1:0] ADDR_ALL_ZEROS = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;

    // combined telemetry status
    typedef enum logic [1:0] {
        CCM_TLM_NONE = 2'b00,
        CCM_TLM_ONE = 2'b01,
        CCM_TLM_MULTI = 2'b10
    } ccm_tlm_t;

    // bring a complemented word back to true form
    function automatic logic [ADDR_W-1:0] ccm_normalize(input logic [CMD_W-1:0] word);
        ccm_normalize = word[FORM_BIT] ? ~word[ADDR_W-1:0] : word[ADDR_W-1:0];
    endfunction

    // one-hot decode of a 4-bit field, gated by an enable
    function automatic logic [N_ROW-1:0] ccm_row_decode(input logic [ROW_W-1:0] code,
                                                        input logic en);
        ccm_row_decode = '0;
        if (en) begin
            ccm_row_decode[code] = 1'b1;
        end
    endfunction

endpackage

//--- common/ccm_sel_if.sv
// row and column selects from the decoder to the output grid
interface ccm_sel_if;
    import ccm_pkg::*;

    logic [N_ROW-1:0] row_sel;
    logic [N_COL-1:0] col_sel;

    modport dec (
        output row_sel,
        output col_sel
    );

    modport mat (
        input row_sel,
        input col_sel
    );

endinterface

//--- design/ccm_decoder.sv
module ccm_decoder
    import ccm_pkg::*;
(
    // latched command and read
    input wire logic [ccm_pkg::CMD_W-1:0] addr,
    input wire logic read_cmd,
    // selects to the grid
    ccm_sel_if.dec sel
);

    import ccm_pkg::*;

    logic [ADDR_W-1:0] norm;
    logic [COL_W-1:0] col_code;
    logic [ROW_W-1:0] row_code;

    // complement words fold onto the same true address
    assign norm = ccm_normalize(addr);
    assign col_code = norm[COL_LSB +: COL_W];
    assign row_code = norm[ROW_LSB +: ROW_W];

    // nothing reaches the grid without read
    assign sel.row_sel = ccm_row_decode(row_code, read_cmd);

    genvar c;
    generate
        for (c = 0; c < N_COL; c++) begin : g_col
            assign sel.col_sel[c] = read_cmd &&
                (col_code == COL_W'(c + int'(COL_FIRST)));
        end
    endgenerate

endmodule // ccm_decoder

//--- design/ccm_output_matrix.sv
module ccm_output_matrix
    import ccm_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // command from the computer data adapter
    input wire logic [ccm_pkg::CMD_W-1:0] cmd_word,
    input wire logic cmd_load,
    input wire logic read_cmd,
    input wire logic forced_reset,
    // output channels
    output logic [ccm_pkg::N_CHAN-1:0] channel_out,
    output logic [ccm_pkg::N_CHAN-1:0] channel_mon,
    // telemetry
    output ccm_pkg::ccm_tlm_t tlm_status,
    output logic [ccm_pkg::CNT_W-1:0] active_count,
    output logic reg_test,
    output logic zero_ind
);

    import ccm_pkg::*;

    // reset release synchroniser
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // pin synchronisers
    logic [CMD_W-1:0] word_meta;
    logic [CMD_W-1:0] word_sync;
    logic load_meta;
    logic load_sync;
    logic read_meta;
    logic read_sync;
    logic frst_meta;
    logic frst_sync;

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            word_meta <= ADDR_RESET;
            word_sync <= ADDR_RESET;
            load_meta <= 1'b0;
            load_sync <= 1'b0;
            read_meta <= 1'b0;
            read_sync <= 1'b0;
            frst_meta <= 1'b0;
            frst_sync <= 1'b0;
        end else begin
            word_meta <= cmd_word;
            word_sync <= word_meta;
            load_meta <= cmd_load;
            load_sync <= load_meta;
            read_meta <= read_cmd;
            read_sync <= read_meta;
            frst_meta <= forced_reset;
            frst_sync <= frst_meta;
        end
    end

    // edge detection on the synchronised strobes
    logic load_prev;
    logic read_prev;
    logic load_rise;
    logic read_fall;

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            load_prev <= 1'b0;
            read_prev <= 1'b0;
        end else begin
            load_prev <= load_sync;
            read_prev <= read_sync;
        end
    end

    assign load_rise = load_sync && !load_prev;
    assign read_fall = read_prev && !read_sync;

    // latched command address; cleared by forced reset or when read drops
    logic [CMD_W-1:0] addr;
    logic [CMD_W-1:0] next_addr;

    always_comb begin
        next_addr = addr;
        if (frst_sync || read_fall) begin
            next_addr = ADDR_RESET;
        end else if (load_rise && !read_sync) begin
            // a word is taken only while read is low
            next_addr = word_sync;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            addr <= ADDR_RESET;
        end else begin
            addr <= next_addr;
        end
    end

    // read qualifies decoding only while no forced reset is pending
    logic read_en;

    assign read_en = read_sync && !frst_sync;

    // row and column decode
    ccm_sel_if sel ();

    ccm_decoder u_decoder (
        .addr(addr),
        .read_cmd(read_en),
        .sel(sel.dec)
    );

    // coincidence grid: channel r*7+c is row r, column c
    genvar r;
    genvar c;
    generate
        for (r = 0; r < N_ROW; r++) begin : g_row
            for (c = 0; c < N_COL; c++) begin : g_col
                localparam int IDX = r * N_COL + c;
                always_ff @(posedge clock or negedge rst_sync_n) begin
                    if (!rst_sync_n) begin
                        channel_out[IDX] <= 1'b0;
                    end else begin
                        channel_out[IDX] <= sel.row_sel[r] && sel.col_sel[c];
                    end
                end
                always_ff @(posedge clock or negedge rst_sync_n) begin
                    if (!rst_sync_n) begin
                        channel_mon[IDX] <= 1'b0;
                    end else begin
                        channel_mon[IDX] <= sel.row_sel[r] && sel.col_sel[c];
                    end
                end
            end
        end
    endgenerate

    // count of monitor indications that are on
    function automatic logic [CNT_W-1:0] count_active(input logic [N_CHAN-1:0] v);
        logic [CNT_W-1:0] n;
        n = CNT_ZERO;
        for (int i = 0; i < N_CHAN; i++) begin
            n = n + CNT_W'(v[i]);
        end
        count_active = n;
    endfunction

    logic [CNT_W-1:0] next_count;

    assign next_count = count_active(channel_mon);

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            active_count <= CNT_ZERO;
        end else begin
            active_count <= next_count;
        end
    end

    // merged telemetry status
    ccm_tlm_t next_tlm;

    always_comb begin
        if (next_count == CNT_ZERO) begin
            next_tlm = CCM_TLM_NONE;
        end else if (next_count == CNT_ONE) begin
            next_tlm = CCM_TLM_ONE;
        end else begin
            // several drivers at once is a fault and is reported, not hidden
            next_tlm = CCM_TLM_MULTI;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tlm_status <= CCM_TLM_NONE;
        end else begin
            tlm_status <= next_tlm;
        end
    end

    // self-test outputs from the raw latched word
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_test <= 1'b0;
        end else begin
            reg_test <= (addr == ADDR_ALL_ONES) && read_en;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            zero_ind <= 1'b0;
        end else begin
            zero_ind <= (addr == ADDR_ALL_ZEROS);
        end
    end

endmodule // ccm_output_matrix

//--- testbench/ccm_adapter_model.sv
module ccm_adapter_model
    import ccm_pkg::*;
(
    // clock
    input wire logic clock,
    // command lines
    output logic [ccm_pkg::CMD_W-1:0] cmd_word,
    output logic cmd_load,
    output logic read_cmd,
    output logic forced_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cmd_word = ADDR_RESET;
        cmd_load = 1'b0;
        read_cmd = 1'b0;
        forced_reset = 1'b0;
    end
    // word settles before the strobe; read only once the load is over
    task automatic issue(input logic [CMD_W-1:0] word, input logic blk);
        @(negedge clock);
        cmd_word = word;
        repeat (3) @(negedge clock);
        cmd_load = 1'b1;
        repeat (2) @(negedge clock);
        cmd_load = 1'b0;
        forced_reset = blk;
        repeat (3) @(negedge clock);
        read_cmd = 1'b1;
        repeat (6) @(negedge clock);
    endtask
    // word lines turn over once read is gone, so a stale word is never reused
    task automatic drop();
        read_cmd = 1'b0;
        cmd_word = ~cmd_word;
        forced_reset = 1'b0;
        repeat (8) @(negedge clock);
    endtask
    // a word offered while read still stands; the block has to ignore it
    task automatic reload(input logic [CMD_W-1:0] word);
        @(negedge clock);
        cmd_word = word;
        repeat (3) @(negedge clock);
        cmd_load = 1'b1;
        repeat (2) @(negedge clock);
        cmd_load = 1'b0;
        repeat (6) @(negedge clock);
    endtask
endmodule // ccm_adapter_model

//--- testbench/ccm_output_matrix_assertions.sv
module ccm_checker
    import ccm_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // watched ports
    input wire logic read_cmd,
    input wire logic [ccm_pkg::N_CHAN-1:0] channel_out,
    input wire logic [ccm_pkg::N_CHAN-1:0] channel_mon,
    input wire ccm_pkg::ccm_tlm_t tlm_status,
    input wire logic [ccm_pkg::CNT_W-1:0] active_count,
    input wire logic reg_test,
    input wire logic zero_ind
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_one; $onehot0(channel_out); endproperty
    a_one: assert property (p_one) else $error("several channels on");
    property p_mon; channel_mon == channel_out; endproperty
    a_mon: assert property (p_mon) else $error("monitor differs");
    property p_cnt; int'(active_count) == $countones($past(channel_mon)); endproperty
    a_cnt: assert property (p_cnt) else $error("count wrong");
    property p_tlm; tlm_status == (active_count == CNT_ZERO ? CCM_TLM_NONE :
        active_count == CNT_ONE ? CCM_TLM_ONE : CCM_TLM_MULTI); endproperty
    a_tlm: assert property (p_tlm) else $error("status wrong");
    property p_idle; !read_cmd [*4] |=> channel_out == '0 && !reg_test; endproperty
    a_idle: assert property (p_idle) else $error("output without read");
    property p_drop; $fell(read_cmd) |-> ##4 channel_out == '0
        ##1 zero_ind && tlm_status == CCM_TLM_NONE; endproperty
    a_drop: assert property (p_drop) else $error("no clear after read");
    property p_reg; reg_test |-> ($past(read_cmd, 2) || $past(read_cmd, 4))
        && channel_out == '0; endproperty
    a_reg: assert property (p_reg) else $error("register test wrong");
    property p_zero; zero_ind |-> channel_out == '0 && !reg_test; endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule // ccm_checker

bind ccm_output_matrix ccm_checker ccm_checker_inst (.clock, .rst_n, .read_cmd, .channel_out,
    .channel_mon, .tlm_status, .active_count, .reg_test, .zero_ind);

//--- testbench/tb_top.sv
module tb_top;
    import ccm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [CMD_W-1:0] cmd_word;
    logic cmd_load, read_cmd, forced_reset, reg_test, zero_ind;
    logic [N_CHAN-1:0] channel_out, channel_mon;
    ccm_tlm_t tlm_status;
    logic [CNT_W-1:0] active_count;
    int num_errors = 0;
    int tests_run = 0;
    logic [CMD_W-1:0] words [10] = '{8'h01, 8'hfe, 8'h7f, 8'h80, 8'h55, 8'haa,
        8'h0f, 8'hf0, 8'hff, 8'h00};
    always #5 clock = ~clock;
    ccm_adapter_model ccm_adapter_model_inst (.clock, .cmd_word, .cmd_load, .read_cmd,
        .forced_reset);
    ccm_output_matrix ccm_output_matrix_inst (.clock, .rst_n, .cmd_word, .cmd_load, .read_cmd,
        .forced_reset, .channel_out, .channel_mon, .tlm_status, .active_count, .reg_test,
        .zero_ind);
    task automatic chk(input logic [N_CHAN-1:0] got, input logic [N_CHAN-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // expected channel worked out from the word, true or complemented
    task automatic t_channel(input logic [CMD_W-1:0] w);
        logic [6:0] n;
        logic [N_CHAN-1:0] exp;
        n = w[7] ? ~w[6:0] : w[6:0];
        exp = '0;
        if (n[2:0] != 3'h0) begin
            exp[n[6:3] * 7 + n[2:0] - 1] = 1'b1;
        end
        ccm_adapter_model_inst.issue(w, 1'b0);
        chk(channel_out, exp);
        chk(channel_mon, exp);
        chk(active_count, (exp == '0) ? 7'h00 : 7'h01);
        chk(tlm_status, (exp == '0) ? CCM_TLM_NONE : CCM_TLM_ONE);
        chk(reg_test, w == ADDR_ALL_ONES);
        chk(zero_ind, w == ADDR_ALL_ZEROS);
        ccm_adapter_model_inst.drop();
        chk(channel_out, '0);
        chk(zero_ind, 1'b1);
    endtask
    // a blocked read must leave every driver off
    task automatic t_force();
        ccm_adapter_model_inst.issue(8'h01, 1'b1);
        chk(channel_out, '0);
        chk(zero_ind, 1'b1);
        ccm_adapter_model_inst.drop();
    endtask
    // a load while read is high is refused and the old channel stays
    task automatic t_refuse();
        logic [N_CHAN-1:0] exp;
        exp = '0;
        exp[0] = 1'b1;
        ccm_adapter_model_inst.issue(8'h01, 1'b0);
        ccm_adapter_model_inst.reload(8'h7f);
        chk(channel_out, exp);
        chk(zero_ind, 1'b0);
        ccm_adapter_model_inst.drop();
        chk(zero_ind, 1'b1);
    endtask
    // reset in mid-run clears drivers at once; a held read finds no address
    task automatic t_reset();
        ccm_adapter_model_inst.issue(8'h55, 1'b0);
        rst_n = 1'b0;
        @(negedge clock);
        chk(channel_out, '0);
        chk(zero_ind, 1'b0);
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        chk(channel_out, '0);
        chk(zero_ind, 1'b1);
        ccm_adapter_model_inst.drop();
        chk(channel_out, '0);
    endtask
    initial begin
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        chk(zero_ind, 1'b1);
        foreach (words[i]) begin
            t_channel(words[i]);
        end
        t_force();
        t_refuse();
        t_reset();
        finish_test();
    end
    initial begin
        #20us;
        num_errors++;
        finish_test();
    end
endmodule // tb_top
